// ===== src/pcs_pkg.sv
// package for the program counter and return stack block
// assumes a single core clock domain and an 8-bit register port
package pcs_pkg;

	localparam int PC_W = 15;
	localparam int DEPTH = 16;
	localparam int IDX_W = 5;
	localparam int ADDR_W = 12;

	// register offsets
	localparam logic [11:0] OFS_PC_LOW = 12'h002;
	localparam logic [11:0] OFS_PC_LATCH = 12'h00a;
	localparam logic [11:0] OFS_STAT = 12'hfe0;
	localparam logic [11:0] OFS_MASK = 12'hfe1;
	localparam logic [11:0] OFS_CFG = 12'hfe2;
	localparam logic [11:0] OFS_STACK_INDEX = 12'hfed;
	localparam logic [11:0] OFS_TOP_LOW = 12'hfee;
	localparam logic [11:0] OFS_TOP_HIGH = 12'hfef;

	// reset values
	localparam logic [4:0] STACK_INDEX_RST = 5'h1f;
	localparam logic [14:0] PC_RST = 15'h0000;
	localparam logic [6:0] LATCH_RST = 7'h00;
	localparam logic [1:0] STAT_RST = 2'h0;
	localparam logic [1:0] MASK_RST = 2'h0;
	localparam logic CFG_RST = 1'b0;

	// status bit positions
	localparam int ST_OVF = 0;
	localparam int ST_UNF = 1;

	// core operation codes
	typedef enum logic [3:0] {
		PCS_OP_NONE = 4'h0,
		PCS_OP_STEP = 4'h1,
		PCS_OP_CALL = 4'h2,
		PCS_OP_CALL_VIA_W = 4'h3,
		PCS_OP_BRW = 4'h4,
		PCS_OP_BRA = 4'h5,
		PCS_OP_RET = 4'h6,
		PCS_OP_INT = 4'h7
	} pcs_op_e;

	typedef struct packed {
		pcs_op_e op;
		logic [10:0] operand;
		logic [7:0] accum;
		logic [14:0] vector;
	} pcs_req_s;

	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pcs_bus_s;

endpackage : pcs_pkg

// ===== src/pcs_stack_mem.sv
// return address storage array with one write and one read port
// assumes index is already limited to the array range by the caller
`timescale 1ns/1ps
`default_nettype none
module pcs_stack_mem #(
	parameter int DEPTH = 16,
	parameter int WIDTH = 15
) (
	// clock
	input wire logic clk,
	// write port
	input wire logic wr_en,
	input wire logic [$clog2(DEPTH)-1:0] wr_idx,
	input wire logic [WIDTH-1:0] wr_data,
	// read port
	input wire logic [$clog2(DEPTH)-1:0] rd_idx,
	output logic [WIDTH-1:0] rd_data
);
	if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
		$error("pcs_stack_mem: bad size");
	end

	// no reset: contents are unknown after power up
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	assign rd_data = mem[rd_idx];
endmodule : pcs_stack_mem
`default_nettype wire

// ===== src/pcs_top.sv
// program counter and 16-level return address stack of the core
// assumes the core issues one operation per clock and the register
// port strobes are one cycle long and never together
`timescale 1ns/1ps
`default_nettype none
module pcs_top #(
	parameter int DEPTH = pcs_pkg::DEPTH
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// core operation request
	input wire logic [3:0] OP,
	input wire logic [10:0] OPERAND,
	input wire logic [7:0] ACCUM,
	input wire logic [14:0] VECTOR,
	// program counter out
	output logic [14:0] PC,
	// register port
	input wire logic [11:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// configuration and faults
	output logic STACK_FAULT_RESET,
	output logic IRQ
);
	// the five bit index and its overflow codes only fit sixteen entries
	if (DEPTH != 16) begin : g_bad_depth
		$error("pcs_top: stack index width needs depth 16");
	end

	////////////////////////////////////////////////////////////////////
	// request and bus bundles

	pcs_pkg::pcs_req_s req;
	pcs_pkg::pcs_bus_s bus;
	assign req = '{
		op: pcs_pkg::pcs_op_e'(OP),
		operand: OPERAND,
		accum: ACCUM,
		vector: VECTOR
	};
	assign bus = '{
		addr: ADDR,
		wdata: WDATA,
		wr: WR,
		rd: RD
	};

	////////////////////////////////////////////////////////////////////
	// state

	logic [14:0] pc_q, pc_d;
	logic [6:0] latch_q, latch_d;
	logic [4:0] sidx_q, sidx_d;
	logic [1:0] stat_q, stat_d;
	logic [1:0] mask_q, mask_d;
	logic fault_en_q, fault_en_d;
	logic fault_q, fault_d;
	logic [7:0] rdata_q, rdata_d;

	////////////////////////////////////////////////////////////////////
	// register decode

	wire sel_pcl = bus.addr == pcs_pkg::OFS_PC_LOW;
	wire sel_lat = bus.addr == pcs_pkg::OFS_PC_LATCH;
	wire sel_stat = bus.addr == pcs_pkg::OFS_STAT;
	wire sel_mask = bus.addr == pcs_pkg::OFS_MASK;
	wire sel_cfg = bus.addr == pcs_pkg::OFS_CFG;
	wire sel_idx = bus.addr == pcs_pkg::OFS_STACK_INDEX;
	wire sel_tl = bus.addr == pcs_pkg::OFS_TOP_LOW;
	wire sel_th = bus.addr == pcs_pkg::OFS_TOP_HIGH;

	wire wr_pcl = bus.wr && sel_pcl;
	wire wr_lat = bus.wr && sel_lat;
	wire wr_stat = bus.wr && sel_stat;
	wire wr_mask = bus.wr && sel_mask;
	wire wr_cfg = bus.wr && sel_cfg;
	wire wr_idx = bus.wr && sel_idx;
	wire wr_tl = bus.wr && sel_tl;
	wire wr_th = bus.wr && sel_th;

	////////////////////////////////////////////////////////////////////
	// stack operation decode

	wire do_push = req.op == pcs_pkg::PCS_OP_CALL || req.op == pcs_pkg::PCS_OP_CALL_VIA_W
		|| req.op == pcs_pkg::PCS_OP_INT;
	wire do_pop = req.op == pcs_pkg::PCS_OP_RET;

	// push overflows when the index already sits on the top entry
	wire push_ovf = do_push && sidx_q == 5'h0f;
	// pop underflows when the index is below the first entry
	wire pop_unf = do_pop && sidx_q == 5'h1f;

	wire [4:0] sidx_inc = sidx_q + 5'h01;
	wire [4:0] sidx_dec = sidx_q - 5'h01;
	// wrap inside sixteen entries whether fault reset is on or off
	wire [3:0] push_slot = sidx_inc[3:0];

	////////////////////////////////////////////////////////////////////
	// storage

	logic mem_we;
	logic [3:0] mem_widx;
	logic [14:0] mem_wdata;
	logic [14:0] top_entry;

	wire [14:0] pc_inc = pc_q + 15'h0001;

	assign mem_we = do_push || wr_tl || wr_th;
	assign mem_widx = do_push ? push_slot : sidx_q[3:0];
	assign mem_wdata = do_push ? (req.op == pcs_pkg::PCS_OP_INT ? pc_q : pc_inc) :
		wr_th ? {bus.wdata[6:0], top_entry[7:0]} : {top_entry[14:8], bus.wdata};

	pcs_stack_mem #(
		.DEPTH(DEPTH),
		.WIDTH(pcs_pkg::PC_W)
	) u_mem (
		.clk(CLK),
		.wr_en(mem_we),
		.wr_idx(mem_widx),
		.wr_data(mem_wdata),
		.rd_idx(sidx_q[3:0]),
		.rd_data(top_entry)
	);

	////////////////////////////////////////////////////////////////////
	// next program counter

	wire [14:0] call_tgt = {latch_q[6:3], req.operand};
	wire [14:0] call_via_w_tgt = {latch_q, req.accum};
	wire [14:0] brw_tgt = pc_inc + {7'h00, req.accum};
	wire [14:0] bra_tgt = pc_inc + {{4{req.operand[10]}}, req.operand};

	always_comb begin
		case (req.op)
			pcs_pkg::PCS_OP_STEP: pc_d = pc_inc;
			pcs_pkg::PCS_OP_CALL: pc_d = call_tgt;
			pcs_pkg::PCS_OP_CALL_VIA_W: pc_d = call_via_w_tgt;
			pcs_pkg::PCS_OP_BRW: pc_d = brw_tgt;
			pcs_pkg::PCS_OP_BRA: pc_d = bra_tgt;
			pcs_pkg::PCS_OP_RET: pc_d = top_entry;
			pcs_pkg::PCS_OP_INT: pc_d = req.vector;
			default: pc_d = pc_q;
		endcase
		// low byte write brings the latch into the upper bits
		if (wr_pcl) begin
			pc_d = {latch_q, bus.wdata};
		end
	end

	////////////////////////////////////////////////////////////////////
	// index, latch, flags

	always_comb begin
		sidx_d = sidx_q;
		if (do_push) begin
			// from 5'h1f the five bit increment wraps to 5'h00 by itself
			sidx_d = push_ovf ? 5'h00 : sidx_inc;
		end else if (do_pop) begin
			sidx_d = pop_unf ? 5'h0f : sidx_dec;
		end else if (wr_idx) begin
			sidx_d = bus.wdata[4:0];
		end
	end

	// latch only changes by a software write
	assign latch_d = wr_lat ? bus.wdata[6:0] : latch_q;

	// bit 1 underflow, bit 0 overflow
	wire [1:0] flag_set = {pop_unf, push_ovf};
	assign mask_d = wr_mask ? bus.wdata[1:0] : mask_q;
	assign fault_en_d = wr_cfg ? bus.wdata[0] : fault_en_q;
	assign fault_d = fault_en_q && (push_ovf || pop_unf);

	////////////////////////////////////////////////////////////////////
	// read data, valid only in the cycle after the strobe

	always_comb begin
		rdata_d = 8'h00;
		if (bus.rd) begin
			case (1'b1)
				sel_pcl: rdata_d = pc_q[7:0];
				sel_lat: rdata_d = {1'b0, latch_q};
				sel_stat: rdata_d = {6'h00, stat_q};
				sel_mask: rdata_d = {6'h00, mask_q};
				sel_cfg: rdata_d = {7'h00, fault_en_q};
				sel_idx: rdata_d = {3'h0, sidx_q};
				sel_tl: rdata_d = top_entry[7:0];
				sel_th: rdata_d = {1'b0, top_entry[14:8]};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// registers, one short block each

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pc_q <= pcs_pkg::PC_RST;
		end else begin
			pc_q <= pc_d;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			latch_q <= pcs_pkg::LATCH_RST;
		end else begin
			latch_q <= latch_d;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			sidx_q <= pcs_pkg::STACK_INDEX_RST;
		end else begin
			sidx_q <= sidx_d;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			mask_q <= pcs_pkg::MASK_RST;
		end else begin
			mask_q <= mask_d;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			fault_en_q <= pcs_pkg::CFG_RST;
		end else begin
			fault_en_q <= fault_en_d;
		end
	end

	// pulse only: whoever resets the device must stretch it if needed
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			fault_q <= 1'b0;
		end else begin
			fault_q <= fault_d;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// flags clear on this reset; the system keeps the fault cause across
	// its own stack fault reset. a new event wins over a same-cycle clear
	// so that a late acknowledge never hides a fault
	for (genvar gi = 0; gi < 2; gi++) begin : g_flag
		assign stat_d[gi] = flag_set[gi] | (stat_q[gi] & ~(wr_stat & bus.wdata[gi]));
		always_ff @(posedge CLK or negedge RESET_N) begin
			if (!RESET_N) begin
				stat_q[gi] <= pcs_pkg::STAT_RST[gi];
			end else begin
				stat_q[gi] <= stat_d[gi];
			end
		end
	end

	assign PC = pc_q;
	assign RDATA = rdata_q;
	assign STACK_FAULT_RESET = fault_q;
	assign IRQ = |(stat_q & mask_q);
endmodule : pcs_top
`default_nettype wire

// ===== verification/pcs_core_model.sv
// model of the core execute and interrupt logic
// one op per call, none between calls
`timescale 1ns/1ps
`default_nettype none
module pcs_core_model (
	// clock
	input wire logic clk,
	// op request
	output logic [3:0] op,
	output logic [10:0] operand,
	output logic [7:0] accum,
	output logic [14:0] vector
);
	initial begin
		op = 4'h0;
		operand = 11'h000;
		accum = 8'h00;
		vector = 15'h0000;
	end
	task issue(input logic [3:0] o, input logic [10:0] a, input logic [7:0] w, input logic [14:0] v);
		@(posedge clk);
		op <= o;
		operand <= a;
		accum <= w;
		vector <= v;
		@(posedge clk);
		op <= 4'h0;
		// idle operand changes so a stale operand is never trusted
		operand <= ~a;
		#1;
	endtask : issue
endmodule : pcs_core_model
`default_nettype wire

// ===== verification/pcs_top_asserts.sv
// assertions on the ports of the pc and stack block
// assumes one clock and an async low reset
`timescale 1ns/1ps
`default_nettype none
module pcs_top_asserts (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// core side
	input wire logic [3:0] OP,
	input wire logic [10:0] OPERAND,
	input wire logic [7:0] ACCUM,
	input wire logic [14:0] VECTOR,
	input wire logic [14:0] PC,
	// register port
	input wire logic [11:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	// ops judged without WR: a low byte write overrides them
	a_pc_reset: assert property ($rose(RESET_N) |-> PC == 15'h0000) else $error("pc not cleared");
	a_pc_hold: assert property (OP == 4'h0 && !WR |=> $stable(PC)) else $error("pc moved");
	a_low_write: assert property (WR && ADDR == 12'h002 |=> PC[7:0] == $past(WDATA)) else $error("pcl");
	a_call_target: assert property (OP == 4'h2 && !WR |=> PC[10:0] == $past(OPERAND)) else $error("call");
	a_call_via_w_low: assert property (OP == 4'h3 && !WR |=> PC[7:0] == $past(ACCUM)) else $error("call_via_w");
	a_int_vector: assert property (OP == 4'h7 && !WR |=> PC == $past(VECTOR)) else $error("vector");
	a_brw_sum: assert property (OP == 4'h4 && !WR |=> PC == 15'($past(PC) + $past(ACCUM) + 1))
		else $error("brw");
	a_bra_sum: assert property (OP == 4'h5 && !WR ##1 1 |->
		PC == $past(PC) + 15'h0001 + {{4{$past(OPERAND[10])}}, $past(OPERAND)}) else $error("bra");
	a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("rdata");
endmodule : pcs_top_asserts
`default_nettype wire

// ===== verification/test_pcs_top.sv
// bench for the pc and return stack block
// drives registers directly and ops through the core model
`timescale 1ns/1ps
`default_nettype none
module test_pcs_top;
	logic CLK = 1'b0;
	logic RESET_N = 1'b0;
	logic [11:0] ADDR = 12'h000;
	logic [7:0] WDATA = 8'h00;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic [3:0] OP;
	logic [10:0] OPERAND;
	logic [7:0] ACCUM;
	logic [14:0] VECTOR;
	logic [14:0] PC;
	logic [7:0] RDATA;
	logic STACK_FAULT_RESET;
	logic IRQ;
	logic seen;
	int fail_count = 0;
	int checks = 0;
	always #25 CLK = ~CLK;
	pcs_core_model u_core (.clk(CLK), .op(OP), .operand(OPERAND), .accum(ACCUM), .vector(VECTOR));
	pcs_top u_dut (.CLK, .RESET_N, .OP, .OPERAND, .ACCUM, .VECTOR, .PC, .ADDR, .WDATA, .WR, .RD, .RDATA,
		.STACK_FAULT_RESET, .IRQ);
	////////////////////////////////////////
	task check(input logic [14:0] s, input logic [14:0] e);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %0t seen %h want %h", $time, s, e);
		end
	endtask : check
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
		WDATA <= ~d;
		#1;
	endtask : wr
	task rc(input logic [11:0] a, input logic [7:0] e);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1 check(RDATA, e);
	endtask : rc
	task print_verdict;
		if (fail_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	task t_reset;
		@(posedge CLK);
		RESET_N <= 1'b0;
		repeat (8) @(posedge CLK);
		RESET_N <= 1'b1;
		#1 check(PC, 15'h0000);
		rc(12'hfed, 8'h1f);
		rc(12'h123, 8'h00);
		rc(12'hfe0, 8'h00);
		rc(12'hfe2, 8'h00);
		rc(12'h00a, 8'h00);
		check(IRQ, 1'b0);
	endtask : t_reset
	task t_call;
		wr(12'h00a, 8'h55);
		wr(12'h002, 8'h12);
		check(PC, 15'h5512);
		u_core.issue(4'h2, 11'h3a5, 8'h00, 15'h0000);
		check(PC, 15'h53a5);
		rc(12'hfed, 8'h00);
		rc(12'hfee, 8'h13);
		rc(12'hfef, 8'h55);
		rc(12'h00a, 8'h55);
		u_core.issue(4'h3, 11'h000, 8'h80, 15'h0000);
		check(PC, 15'h5580);
		u_core.issue(4'h4, 11'h000, 8'hff, 15'h0000);
		check(PC, 15'h5680);
		u_core.issue(4'h5, 11'h7ff, 8'h00, 15'h0000);
		check(PC, 15'h5680);
		u_core.issue(4'h6, 11'h000, 8'h00, 15'h0000);
		check(PC, 15'h53a6);
		u_core.issue(4'h6, 11'h000, 8'h00, 15'h0000);
		check(PC, 15'h5513);
		rc(12'hfed, 8'h1f);
	endtask : t_call
	task t_wrap;
		for (int i = 0; i < 17; i++)
			u_core.issue(4'h7, 11'h000, 8'h00, 15'h0100 + 15'(i));
		check(PC, 15'h0110);
		rc(12'hfed, 8'h00);
		rc(12'hfee, 8'h0f);
		rc(12'hfe0, 8'h01);
		check(IRQ, 1'b0);
		wr(12'hfe1, 8'h01);
		check(IRQ, 1'b1);
		wr(12'hfe0, 8'h01);
		check(IRQ, 1'b0);
		u_core.issue(4'h6, 11'h000, 8'h00, 15'h0000);
		check(PC, 15'h010f);
		u_core.issue(4'h6, 11'h000, 8'h00, 15'h0000);
		check(PC, 15'h010e);
		rc(12'hfed, 8'h0f);
		rc(12'hfe0, 8'h02);
	endtask : t_wrap
	task t_fault;
		wr(12'hfed, 8'h05);
		wr(12'hfee, 8'h34);
		wr(12'hfef, 8'hff);
		rc(12'hfef, 8'h7f);
		rc(12'hfee, 8'h34);
		wr(12'hfed, 8'h0f);
		wr(12'hfe2, 8'h01);
		u_core.issue(4'h2, 11'h000, 8'h00, 15'h0000);
		seen = 1'b0;
		repeat (3) begin
			seen = seen | STACK_FAULT_RESET;
			@(posedge CLK);
			#1;
		end
		check(seen, 1'b1);
		rc(12'hfe0, 8'h03);
	endtask : t_fault
	initial begin
		t_reset;
		t_call;
		t_wrap;
		t_fault;
		t_reset;
		print_verdict;
	end
	// run needs about 140 cycles; this leaves wide margin
	initial begin
		#100000;
		fail_count++;
		print_verdict;
	end
endmodule : test_pcs_top
bind pcs_top pcs_top_asserts u_chk (.CLK, .RESET_N, .OP, .OPERAND, .ACCUM, .VECTOR, .PC, .ADDR, .WDATA, .WR,
	.RD, .RDATA);
`default_nettype wire
